// File: rtl/iip_pkg.sv
package iip_pkg;
  // --------------------------------------------------------------------------
  // Notes on behaviour
  // - eight data lines carry one byte at a time, line one least significant.
  // - interface clear held low returns all bus functions to idle; the code keeps parallel poll enable, service request, remote and lockout.
  // - attention low means command bytes, high means device data bytes.
  // - service request is signalled by pulling the request line low.
  // - remote operation only while remote enable is low; full remote/local.
  // - end line low with attention high marks the last data byte.
  // - end line low with attention low starts a parallel poll answer.
  // - source pulls data valid low once its byte is on the lines.
  // - busy acceptor holds not-ready low; source waits until it releases.
  // - not-accepted stays low until the acceptor has taken the byte.
  // - lines are wired-OR; release every line not actively pulled low.
  // - full source handshake for sending bytes.
  // - full acceptor handshake for receiving bytes.
  // - talker with serial poll and listener when addressed.
  // - device clear resets command processing.
  // - device trigger starts the triggered function.
  // - universal commands 10h to 1Fh act without addressing.
  // - addressed commands 00h to 0Fh act only when listener addressed.
  // - device clear aborts received commands, keeps instrument settings.
  // - group trigger acts exactly like an external trigger pulse.
  // --------------------------------------------------------------------------

  // raw bus levels as seen on the pins (low is asserted)
  typedef struct packed {
    logic       ifcN;
    logic       atnN;
    logic       renN;
    logic       eoiN;
    logic       davN;
    logic       nrfdN;
    logic       ndacN;
    logic [7:0] dio;
  } iip_in_t;

  // open-drain controls, a zero pulls the line low
  typedef struct packed {
    logic       srq;
    logic       eoi;
    logic       dav;
    logic       nrfd;
    logic       ndac;
    logic [7:0] dio;
  } iip_drv_t;

  // received data byte with its end mark
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } iip_rx_t;

  typedef enum logic [3:0] {
    S_IDLE   = 4'h1,
    S_SETTLE = 4'h2,
    S_RFD    = 4'h4,
    S_VALID  = 4'h8
  } iip_src_t;

  typedef enum logic [3:0] {
    A_IDLE  = 4'h1,
    A_READY = 4'h2,
    A_TAKE  = 4'h4,
    A_DONE  = 4'h8
  } iip_acc_t;

  // input synchroniser
  localparam int              SYNC_W     = $bits(iip_in_t) + 1;
  localparam logic [SYNC_W-1:0] SYNC_RST = 16'hFFFF;
  localparam iip_drv_t        DRV_RST    = 13'h1FFF;

  // data settling before data valid
  localparam int              CLK_NS     = 40;
  localparam int              SETTLE_NS  = 2000;
  localparam int              SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int              SETTLE_W   = 6;

  // receive buffer
  localparam int              FIFO_DEPTH = 8;

  // command groups on bits 6..4 and 6..5
  localparam logic [2:0]      GRP_ADDR   = 3'h0;
  localparam logic [2:0]      GRP_UNI    = 3'h1;
  localparam logic [1:0]      GRP_LISTEN = 2'h1;
  localparam logic [1:0]      GRP_TALK   = 2'h2;
  localparam logic [1:0]      GRP_SEC    = 2'h3;
  localparam int              PPD_BIT    = 4;

  // command codes
  localparam logic [6:0]      CMD_GTL    = 7'h01;
  localparam logic [6:0]      CMD_SDC    = 7'h04;
  localparam logic [6:0]      CMD_PPC    = 7'h05;
  localparam logic [6:0]      CMD_GET    = 7'h08;
  localparam logic [6:0]      CMD_LLO    = 7'h11;
  localparam logic [6:0]      CMD_DCL    = 7'h14;
  localparam logic [6:0]      CMD_PPU    = 7'h15;
  localparam logic [6:0]      CMD_SPE    = 7'h18;
  localparam logic [6:0]      CMD_SPD    = 7'h19;
  localparam logic [6:0]      CMD_UNL    = 7'h3F;
  localparam logic [6:0]      CMD_UNT    = 7'h5F;

  // status byte service bit
  localparam logic [7:0]      RSV_MASK   = 8'h40;
endpackage : iip_pkg

// File: rtl/iip_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module iip_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             outValid_r;
  logic [WIDTH-1:0] outData_r;
  logic             push;
  logic             pop;

  // full and empty decode
  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign push     = inValid & inReady;
  assign pop      = (count_r != '0) & (~outValid_r | outReady);
  assign outValid = outValid_r;
  assign outData  = outData_r;

  // storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // pointers, fill level and output stage
  always_ff @(posedge clk) begin
    if (!nrst || flush) begin
      wrPtr_r    <= '0;
      rdPtr_r    <= '0;
      count_r    <= '0;
      outValid_r <= 1'b0;
      outData_r  <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= rdPtr_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
      if (pop) begin
        outValid_r <= 1'b1;
        outData_r  <= mem[rdPtr_r];
      end else if (outReady) begin
        outValid_r <= 1'b0;
      end
    end
  end
endmodule : iip_fifo
`default_nettype wire

// File: rtl/iip_port.sv
`timescale 1ns/1ps
`default_nettype none
module iip_port (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // bus pins: raw levels in, pull-down controls out
  input  wire iip_pkg::iip_in_t  lineIn,
  output var  iip_pkg::iip_drv_t lineOut,
  output var  iip_pkg::iip_drv_t lineDrvN,
  // instrument settings
  input  wire logic [4:0]        myAddr,
  input  wire logic              extTrigIn,
  input  wire logic              localReq,
  // received bytes
  output var  iip_pkg::iip_rx_t  rxData,
  output logic                   rxValid,
  input  wire logic              rxReady,
  // bytes to send
  input  wire logic [7:0]        txData,
  input  wire logic              txLast,
  input  wire logic              txValid,
  output logic                   txReady,
  // service request
  input  wire logic [7:0]        statusByte,
  input  wire logic              svcReq,
  output logic                   srqPending,
  // states and events
  output logic                   remoteMode,
  output logic                   lockedOut,
  output logic                   listening,
  output logic                   talking,
  output logic                   devClear,
  output logic                   devTrigger
);
  import iip_pkg::*;

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  logic [SYNC_W-1:0] rawIn;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync3_r;
  logic [SYNC_W-1:0] filt_r;
  logic [SYNC_W-1:0] filt_nxt;

  // a bit changes once the second and third stages agree
  assign rawIn    = {extTrigIn, lineIn};
  assign filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
      sync3_r <= SYNC_RST;
      filt_r  <= SYNC_RST;
    end else begin
      sync1_r <= rawIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= filt_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // line levels, asserted high
  // --------------------------------------------------------------------------
  iip_in_t    lv;
  logic       extLvl;
  logic       ifc;
  logic       atn;
  logic       ren;
  logic       eoi;
  logic       dav;
  logic       nrfdLo;
  logic       ndacLo;
  logic [7:0] busByte;

  assign lv      = filt_r[SYNC_W-2:0];
  assign extLvl  = filt_r[SYNC_W-1];
  assign ifc     = ~lv.ifcN;
  assign atn     = ~lv.atnN;
  assign ren     = ~lv.renN;
  assign eoi     = ~lv.eoiN;
  assign dav     = ~lv.davN;
  assign nrfdLo  = ~lv.nrfdN;
  assign ndacLo  = ~lv.ndacN;
  assign busByte = ~lv.dio; // low line is a one, first line is bit 0

  // --------------------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------------------
  iip_src_t            src_r;
  iip_src_t            src_nxt;
  iip_acc_t            acc_r;
  iip_acc_t            acc_nxt;
  logic                listen_r;
  logic                listen_nxt;
  logic                talk_r;
  logic                talk_nxt;
  logic                spas_r;
  logic                spas_nxt;
  logic                ppcPend_r;
  logic                ppcPend_nxt;
  logic                ppEn_r;
  logic                ppEn_nxt;
  logic                ppSense_r;
  logic [2:0]          ppLine_r;
  logic                remote_r;
  logic                remote_nxt;
  logic                lockout_r;
  logic                lockout_nxt;
  logic                srqPend_r;
  logic                srqPend_nxt;
  logic [7:0]          txByte_r;
  logic [7:0]          txByte_nxt;
  logic                txEoi_r;
  logic                txEoi_nxt;
  logic [SETTLE_W-1:0] settle_r;
  logic                txReady_r;
  logic                devClear_r;
  logic                devClear_nxt;
  logic                devTrig_r;
  logic                devTrig_nxt;
  logic                extPrev_r;
  iip_drv_t            drvN_r;
  iip_drv_t            drvN_nxt;

  // --------------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------------
  logic [6:0] cmd;
  logic       cmdTake;
  logic       cmdUni;
  logic       cmdAddr;
  logic       isMla;
  logic       isUnl;
  logic       isMta;
  logic       isTalk;
  logic       isUnt;
  logic       isSec;
  logic       ppeTake;

  // attention low frames a command byte
  assign cmdTake = (acc_r == A_TAKE) & atn;
  assign cmd     = busByte[6:0];
  assign cmdUni  = cmdTake & (cmd[6:4] == GRP_UNI);
  assign cmdAddr = cmdTake & (cmd[6:4] == GRP_ADDR) & listen_r;
  assign isMla   = cmd == {GRP_LISTEN, myAddr};
  assign isUnl   = cmd == CMD_UNL;
  assign isMta   = cmd == {GRP_TALK, myAddr};
  assign isTalk  = cmd[6:5] == GRP_TALK;
  assign isUnt   = cmd == CMD_UNT;
  assign isSec   = cmd[6:5] == GRP_SEC;
  assign ppeTake = cmdTake & isSec & ppcPend_r;

  // --------------------------------------------------------------------------
  // addressing, poll and remote state
  // --------------------------------------------------------------------------
  assign listen_nxt  = ifc ? 1'b0 :
                       (cmdTake & isMla) ? 1'b1 :
                       (cmdTake & isUnl) ? 1'b0 : listen_r;
  assign talk_nxt    = ifc ? 1'b0 :
                       (cmdTake & isMta) ? 1'b1 :
                       (cmdTake & (isUnt | isTalk)) ? 1'b0 : talk_r;
  assign spas_nxt    = ifc ? 1'b0 :
                       (cmdUni & (cmd == CMD_SPE)) ? 1'b1 :
                       (cmdUni & (cmd == CMD_SPD)) ? 1'b0 : spas_r;
  assign ppcPend_nxt = ifc ? 1'b0 :
                       (cmdTake & ~isSec) ? (cmdAddr & (cmd == CMD_PPC)) : ppcPend_r;
  assign ppEn_nxt    = (cmdUni & (cmd == CMD_PPU)) ? 1'b0 :
                       ppeTake ? ~cmd[PPD_BIT] : ppEn_r;
  assign remote_nxt  = ~ren ? 1'b0 :
                       (cmdTake & isMla) ? 1'b1 :
                       ((cmdAddr & (cmd == CMD_GTL)) | (localReq & ~lockout_r)) ? 1'b0 : remote_r;
  assign lockout_nxt = ~ren ? 1'b0 :
                       (cmdUni & (cmd == CMD_LLO)) ? 1'b1 : lockout_r;

  // clear and trigger events
  assign devClear_nxt = (cmdUni & (cmd == CMD_DCL)) | (cmdAddr & (cmd == CMD_SDC));
  assign devTrig_nxt  = (cmdAddr & (cmd == CMD_GET)) | (extLvl & ~extPrev_r);

  // --------------------------------------------------------------------------
  // acceptor handshake
  // --------------------------------------------------------------------------
  logic accActive;
  logic canTake;
  logic fifoInReady;
  logic fifoPush;

  assign accActive = atn | listen_r;
  assign canTake   = atn | fifoInReady;
  assign fifoPush  = (acc_r == A_TAKE) & ~atn;

  always_comb begin
    acc_nxt = acc_r;
    unique case (acc_r)
      A_IDLE:  if (accActive) acc_nxt = A_READY;
      A_READY: begin
        if (!accActive) acc_nxt = A_IDLE;
        else if (dav && canTake) acc_nxt = A_TAKE;
      end
      A_TAKE:  acc_nxt = A_DONE;
      A_DONE:  if (!dav) acc_nxt = accActive ? A_READY : A_IDLE;
    endcase
    if (ifc) acc_nxt = A_IDLE;
  end

  // --------------------------------------------------------------------------
  // source handshake and serial poll
  // --------------------------------------------------------------------------
  logic       srcGo;
  logic       srcAbort;
  logic       srcLoad;
  logic       srcDone;
  logic [7:0] stByte;

  assign srcAbort = atn | ifc | ~talk_r;
  assign srcGo    = ~srcAbort & (spas_r | txValid);
  assign srcLoad  = (src_r == S_IDLE) & srcGo;
  assign srcDone  = (src_r == S_VALID) & ~ndacLo & ~srcAbort;
  assign stByte   = (statusByte & ~RSV_MASK) | (srqPend_r ? RSV_MASK : 8'h00);
  assign txByte_nxt = ~srcLoad ? txByte_r : spas_r ? stByte : txData;
  assign txEoi_nxt  = ~srcLoad ? txEoi_r : (~spas_r & txLast);

  always_comb begin
    src_nxt = src_r;
    unique case (src_r)
      S_IDLE:   if (srcGo) src_nxt = S_SETTLE;
      S_SETTLE: if (settle_r == '0) src_nxt = S_RFD;
      S_RFD:    if (!nrfdLo) src_nxt = S_VALID;
      S_VALID:  if (!ndacLo) src_nxt = S_IDLE;
    endcase
    if (srcAbort) src_nxt = S_IDLE;
  end

  // service request is set by the instrument, cleared once polled
  assign srqPend_nxt = svcReq | (srqPend_r & ~(srcDone & spas_r & txByte_r[6]));

  // --------------------------------------------------------------------------
  // line drivers, released unless pulled
  // --------------------------------------------------------------------------
  logic       srcOn;
  logic       ppRespond;
  logic [7:0] ppMask;

  assign srcOn     = src_nxt != S_IDLE;
  assign ppRespond = atn & eoi & ppEn_r & (srqPend_r == ppSense_r);
  assign ppMask    = ppRespond ? (8'h01 << ppLine_r) : 8'h00;

  always_comb begin
    drvN_nxt.srq  = ~srqPend_r;
    drvN_nxt.dio  = ~((srcOn ? txByte_nxt : 8'h00) | ppMask);
    drvN_nxt.eoi  = ~(srcOn & txEoi_nxt);
    drvN_nxt.dav  = ~(src_nxt == S_VALID);
    drvN_nxt.nrfd = ~(((acc_nxt == A_READY) & ~canTake) |
                      (acc_nxt == A_TAKE) | (acc_nxt == A_DONE));
    drvN_nxt.ndac = ~((acc_nxt == A_READY) | (acc_nxt == A_TAKE));
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      src_r     <= S_IDLE;
      acc_r     <= A_IDLE;
      drvN_r    <= DRV_RST;
      txByte_r  <= 8'h00;
      txEoi_r   <= 1'b0;
      settle_r  <= '0;
      txReady_r <= 1'b0;
    end else begin
      src_r     <= src_nxt;
      acc_r     <= acc_nxt;
      drvN_r    <= drvN_nxt;
      txByte_r  <= txByte_nxt;
      txEoi_r   <= txEoi_nxt;
      settle_r  <= srcLoad ? SETTLE_W'(SETTLE_CYC - 1) :
                   (settle_r != '0) ? settle_r - 1'b1 : settle_r;
      txReady_r <= srcLoad & ~spas_r;
    end
  end

  // interface function flags
  always_ff @(posedge clk) begin
    if (!nrst) begin
      listen_r  <= 1'b0;
      talk_r    <= 1'b0;
      spas_r    <= 1'b0;
      ppcPend_r <= 1'b0;
      ppEn_r    <= 1'b0;
      remote_r  <= 1'b0;
      lockout_r <= 1'b0;
      srqPend_r <= 1'b0;
    end else begin
      listen_r  <= listen_nxt;
      talk_r    <= talk_nxt;
      spas_r    <= spas_nxt;
      ppcPend_r <= ppcPend_nxt;
      ppEn_r    <= ppEn_nxt;
      remote_r  <= remote_nxt;
      lockout_r <= lockout_nxt;
      srqPend_r <= srqPend_nxt;
    end
  end

  // poll configuration and event pulses
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ppSense_r  <= 1'b0;
      ppLine_r   <= 3'h0;
      devClear_r <= 1'b0;
      devTrig_r  <= 1'b0;
      extPrev_r  <= 1'b1;
    end else begin
      if (ppeTake) ppSense_r <= cmd[3];
      if (ppeTake) ppLine_r <= cmd[2:0];
      devClear_r <= devClear_nxt;
      devTrig_r  <= devTrig_nxt;
      extPrev_r  <= extLvl;
    end
  end

  // --------------------------------------------------------------------------
  // receive buffer, flushed by a device clear
  // --------------------------------------------------------------------------
  logic [8:0] fifoOut;

  iip_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) rxFifo (
    .clk      (clk),
    .nrst     (nrst),
    .flush    (devClear_nxt),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .inData   ({eoi, busByte}),
    .outValid (rxValid),
    .outData  (fifoOut),
    .outReady (rxReady)
  );

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign rxData     = fifoOut;
  assign lineOut    = drvN_r;
  assign lineDrvN   = drvN_r;
  assign txReady    = txReady_r;
  assign srqPending = srqPend_r;
  assign remoteMode = remote_r;
  assign lockedOut  = lockout_r;
  assign listening  = listen_r;
  assign talking    = talk_r;
  assign devClear   = devClear_r;
  assign devTrigger = devTrig_r;
endmodule : iip_port
`default_nettype wire

// File: dv/iip_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module iip_port_properties (
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // bus side
  input wire iip_pkg::iip_in_t  lineIn,
  input wire iip_pkg::iip_drv_t lineDrvN,
  // user side
  input wire iip_pkg::iip_rx_t  rxData,
  input wire logic              rxValid,
  input wire logic              rxReady,
  input wire logic              txValid,
  input wire logic              txReady,
  input wire logic              srqPending,
  input wire logic              remoteMode,
  input wire logic              lockedOut,
  input wire logic              listening,
  input wire logic              talking,
  input wire logic              devClear
);
  import iip_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // multi-cycle conditions on the bus
  sequence s_dav_held;
    !lineDrvN.dav && $past(!lineDrvN.dav);
  endsequence
  sequence s_ifc_held;
    !lineIn.ifcN [*8];
  endsequence
  sequence s_ren_off;
    lineIn.renN [*8];
  endsequence
  // source and acceptor handshake
  a_dav_after_rfd: assert property ($fell(lineDrvN.dav) |-> $past(lineIn.nrfdN))
    else $error("data valid raised while not ready");
  a_data_held: assert property (s_dav_held |-> $stable(lineDrvN.dio) && $stable(lineDrvN.eoi))
    else $error("data moved while valid");
  a_dav_release: assert property ($rose(lineDrvN.dav) |-> $past(lineIn.ndacN))
    else $error("data valid dropped before acceptance");
  a_ndac_accept: assert property ($rose(lineDrvN.ndac) && lineIn.ifcN && !$past(lineIn.davN) |-> !lineDrvN.nrfd)
    else $error("accepted without holding not ready");
  a_tx_taken: assert property (txReady |-> $past(txValid) && !$past(txReady) && lineDrvN.dav)
    else $error("bad byte take pulse");
  a_rx_hold: assert property (rxValid && !rxReady |=> (rxValid && $stable(rxData)) || devClear)
    else $error("received byte lost while stalled");
  // service request, clear, remote
  a_srq_pull: assert property (srqPending == $past(srqPending) && srqPending == $past(srqPending, 2)
    |-> lineDrvN.srq == !srqPending)
    else $error("request line does not follow pending");
  a_ifc_idle: assert property (s_ifc_held |-> !listening && !talking
    && {lineDrvN.eoi, lineDrvN.dav, lineDrvN.nrfd, lineDrvN.ndac, lineDrvN.dio} == 12'hFFF)
    else $error("interface not idle under clear");
  a_ren_local: assert property (s_ren_off |-> !remoteMode && !lockedOut)
    else $error("remote without remote enable");
  a_clear_taken: assert property (devClear |-> !lineDrvN.nrfd && !$past(devClear))
    else $error("clear pulse outside a handshake");
  a_listen_cmd: assert property ($rose(listening) |-> !lineIn.atnN)
    else $error("addressed without attention");
endmodule : iip_port_properties
`default_nettype wire

// File: dv/iip_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module iip_ctrl_model (
  // clock and device pull-downs
  input  wire logic              clk,
  input  wire iip_pkg::iip_drv_t dev,
  // resolved bus levels
  output var  iip_pkg::iip_in_t  bus
);
  import iip_pkg::*;
  iip_in_t c = '1;
  // wired-AND of both parties, pull-ups on every line
  assign bus = '{c.ifcN, c.atnN, c.renN, c.eoiN & dev.eoi, c.davN & dev.dav,
    c.nrfdN & dev.nrfd, c.ndacN & dev.ndac, c.dio & dev.dio};
  // interface clear and remote enable levels
  task automatic lines(input logic ifcN, input logic renN);
    @(negedge clk);
    c.ifcN = ifcN;
    c.renN = renN;
  endtask : lines
  // source one byte, attention level selects command or data
  task automatic send(input logic atnN, input logic [7:0] b, input logic last);
    @(negedge clk);
    c.atnN = atnN;
    repeat (6) @(negedge clk);
    c.nrfdN = 1'b1;
    c.ndacN = 1'b1;
    c.dio   = ~b;
    c.eoiN  = ~last;
    repeat (3) @(negedge clk);
    while (!bus.nrfdN) @(negedge clk);
    c.davN = 1'b0;
    while (!bus.ndacN) @(negedge clk);
    c.davN = 1'b1;
    c.dio  = 8'hFF;
    c.eoiN = 1'b1;
  endtask : send
  // accept one byte from the device, then hold not ready
  task automatic take(output logic [7:0] b, output logic last);
    @(negedge clk);
    c.atnN  = 1'b1;
    c.ndacN = 1'b0;
    c.nrfdN = 1'b1;
    while (bus.davN) @(negedge clk);
    b       = ~bus.dio;
    last    = ~bus.eoiN;
    c.nrfdN = 1'b0;
    c.ndacN = 1'b1;
    while (!bus.davN) @(negedge clk);
    c.ndacN = 1'b0;
  endtask : take
  // parallel poll: attention and end line low together
  task automatic ppoll(output logic [7:0] b);
    @(negedge clk);
    c.atnN = 1'b0;
    c.eoiN = 1'b0;
    repeat (8) @(negedge clk);
    b      = ~bus.dio;
    c.eoiN = 1'b1;
  endtask : ppoll
endmodule : iip_ctrl_model
`default_nettype wire

// File: dv/iip_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module iip_port_test;
  import iip_pkg::*;
  localparam logic [4:0] ADDR = 5'h07;
  localparam logic [7:0] STAT = 8'h81;
  // design pins
  logic       clk = 1'b0, nrst = 1'b0, extTrigIn = 1'b0, rxReady = 1'b1;
  logic       txLast = 1'b0, txValid = 1'b0, svcReq = 1'b0, localReq = 1'b0;
  logic [7:0] txData = 8'h00;
  logic       rxValid, txReady, srqPending, remoteMode, lockedOut;
  logic       listening, talking, devClear, devTrigger;
  iip_in_t    lineIn;
  iip_drv_t   lineOut, lineDrvN;
  iip_rx_t    rxData;
  int         fails = 0, checkCount = 0, cycles = 0, trigs = 0, clrs = 0;
  // design and bus controller
  iip_port u_iip_port (.clk, .nrst, .lineIn, .lineOut, .lineDrvN, .myAddr(ADDR), .extTrigIn,
    .localReq, .rxData, .rxValid, .rxReady, .txData, .txLast, .txValid, .txReady,
    .statusByte(STAT), .svcReq, .srqPending, .remoteMode, .lockedOut, .listening, .talking,
    .devClear, .devTrigger);
  iip_ctrl_model u_iip_ctrl_model (.clk, .dev(lineDrvN), .bus(lineIn));
  // clock, pulse counts and hang limit
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    trigs += devTrigger;
    clrs  += devClear;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic cmd(input logic [7:0] b);
    u_iip_ctrl_model.send(1'b0, b, 1'b0);
  endtask : cmd
  // listen, fill the buffer until refused, drain it
  task automatic t_listen_fifo();
    logic [7:0] i;
    u_iip_ctrl_model.lines(1'b1, 1'b0);
    rxReady = 1'b0;
    cmd({3'h1, ADDR});
    check(listening, 8'h01);
    check(remoteMode, 8'h01);
    for (i = 8'h00; i < 8'h09; i++) u_iip_ctrl_model.send(1'b1, 8'hA0 + i, i == 8'h08);
    idle(12);
    check(lineIn.nrfdN, 8'h00);
    for (i = 8'h00; i < 8'h09; i++) begin
      check(rxData.data, 8'hA0 + i);
      check(rxData.last, i == 8'h08);
      rxReady = 1'b1;
      @(negedge clk);
      rxReady = 1'b0;
      idle(2);
    end
    check(rxValid, 8'h00);
    rxReady = 1'b1;
  endtask : t_listen_fifo
  // trigger and clear, addressed versus universal
  task automatic t_trigger();
    int t0, c0;
    t0 = trigs;
    c0 = clrs;
    cmd({1'b0, CMD_GET});
    extTrigIn = 1'b1;
    idle(8);
    extTrigIn = 1'b0;
    cmd({1'b0, CMD_UNL});
    cmd({1'b0, CMD_GET});
    cmd({1'b0, CMD_SDC});
    idle(3);
    check(8'(trigs - t0), 8'h02);
    check(8'(clrs - c0), 8'h00);
    cmd({1'b0, CMD_DCL});
    idle(3);
    check(8'(clrs - c0), 8'h01);
  endtask : t_trigger
  // talk one byte, then serial poll with service request
  task automatic t_talk_poll();
    logic [7:0] b;
    logic       l;
    cmd({3'h2, ADDR});
    check(talking, 8'h01);
    txData  = 8'h5A;
    txLast  = 1'b1;
    txValid = 1'b1;
    // attention must drop before the source loads, so the take runs alongside
    fork
      u_iip_ctrl_model.take(b, l);
      begin
        do @(negedge clk); while (txReady !== 1'b1);
        txValid = 1'b0;
      end
    join
    check(b, 8'h5A);
    check(l, 8'h01);
    svcReq = 1'b1;
    @(negedge clk);
    svcReq = 1'b0;
    idle(2);
    check(lineDrvN.srq, 8'h00);
    cmd({1'b0, CMD_SPE});
    u_iip_ctrl_model.take(b, l);
    check(b, STAT | RSV_MASK);
    check(l, 8'h00);
    idle(2);
    check(srqPending, 8'h00);
    cmd({1'b0, CMD_SPD});
    cmd({1'b0, CMD_UNT});
    check(talking, 8'h00);
  endtask : t_talk_poll
  // parallel poll configured, answered, unconfigured
  task automatic t_ppoll();
    logic [7:0] b;
    cmd({3'h1, ADDR});
    cmd({1'b0, CMD_PPC});
    cmd(8'h6A);
    cmd({1'b0, CMD_UNL});
    u_iip_ctrl_model.ppoll(b);
    check(b, 8'h00);
    svcReq = 1'b1;
    @(negedge clk);
    svcReq = 1'b0;
    u_iip_ctrl_model.ppoll(b);
    check(b, 8'h04);
    cmd({1'b0, CMD_PPU});
    u_iip_ctrl_model.ppoll(b);
    check(b, 8'h00);
  endtask : t_ppoll
  // lockout, interface clear, remote enable withdrawn
  task automatic t_ifc_ren();
    cmd({3'h1, ADDR});
    cmd({1'b0, CMD_LLO});
    check(lockedOut, 8'h01);
    localReq = 1'b1;
    idle(1);
    localReq = 1'b0;
    check(remoteMode, 8'h01);
    cmd({1'b0, CMD_GTL});
    check(remoteMode, 8'h00);
    u_iip_ctrl_model.lines(1'b0, 1'b0);
    idle(10);
    check(listening, 8'h00);
    check(lineOut.dio, 8'hFF);
    u_iip_ctrl_model.lines(1'b1, 1'b1);
    idle(10);
    check({remoteMode, lockedOut}, 8'h00);
  endtask : t_ifc_ren
  // main sequence
  initial begin
    idle(4);
    nrst = 1'b1;
    idle(4);
    t_listen_fifo();
    t_trigger();
    t_talk_poll();
    t_ppoll();
    t_ifc_ren();
    report_and_stop();
  end
endmodule : iip_port_test
bind iip_port iip_port_properties u_iip_port_properties (.clk, .nrst, .lineIn, .lineDrvN, .rxData,
  .rxValid, .rxReady, .txValid, .txReady, .srqPending, .remoteMode, .lockedOut, .listening,
  .talking, .devClear);
`default_nettype wire
